// file: port_pin_pkg.sv
// Shared constants and types for the microcontroller port pin control block.
`default_nettype none
package port_pin_pkg;

  // ----------------------------------------------------------------
  // Port widths
  // ----------------------------------------------------------------
  localparam int FIRST_WIDTH = 8;
  localparam int SECOND_WIDTH = 8;
  localparam int THIRD_WIDTH = 6;
  localparam int PIN_COUNT = FIRST_WIDTH + SECOND_WIDTH + THIRD_WIDTH + 2;

  // ----------------------------------------------------------------
  // Positions of the pins in the synchroniser vector
  // ----------------------------------------------------------------
  localparam int FIRST_POS = 0;
  localparam int SECOND_POS = 8;
  localparam int THIRD_POS = 16;
  localparam int INT_POS = 22;
  localparam int RESET_POS = 23;

  // ----------------------------------------------------------------
  // Third port bits with timer functions
  // ----------------------------------------------------------------
  localparam int CAPTURE_BIT = 0;
  localparam int COMPARE_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DIRECTION_RESET = 8'h00;
  localparam logic [7:0] VALUE_RESET = 8'h00;
  localparam logic [1:0] TRIGGER_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Timing: reset pin drive after a watchdog trip
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_PS = 4000;
  localparam int RESET_DRIVE_NS = 500;
  localparam int RESET_DRIVE_CYCLES = (RESET_DRIVE_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int RESET_COUNT_WIDTH = 8;

  // ----------------------------------------------------------------
  // External interrupt trigger modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TRIGGER_LOW_LEVEL = 2'h0,
    TRIGGER_RISING = 2'h1,
    TRIGGER_FALLING = 2'h2,
    TRIGGER_BOTH = 2'h3
  } trigger_mode_t;

endpackage : port_pin_pkg
`default_nettype wire

// file: pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 24,
  parameter logic [WIDTH-1:0] RESET_LEVEL = '1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);
  wire [WIDTH-1:0] next_level = (agree & stage3) | (~agree & level);

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      stage1 <= RESET_LEVEL;
      stage2 <= RESET_LEVEL;
      stage3 <= RESET_LEVEL;
      level <= RESET_LEVEL;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= next_level;
    end
  end

endmodule : pin_sync
`default_nettype wire

// file: port_pin_control.sv
// Pin-level I/O block: three ports, reset pin and external interrupt pin.
//
// Operation
// [RULE1] First port: eight lines, direction and data registers.
// [RULE2] Option selects push-pull or open-drain first port.
// [RULE3] Second port: eight lines, direction and data registers.
// [RULE4] Option: third port lines are falling-edge interrupts.
// [RULE5] Other option: third port lines are pulled-up inputs.
// [RULE6] Option routes third bit0 to capture, no pull-up.
// [RULE7] Option drives third bit1 from compare, no pull-up.
// [RULE8] Low reset pin resets all, never masked; the drive counter clears on rst only.
// [RULE9] Watchdog trip drives the reset pin low.
// [RULE10] External interrupt has four software-selected trigger modes.
// [RULE11] Third port six lines; twenty-two lines in total.
// [RULE12] Direction one drives data; zero reads the pin.
// [RULE13] Third port request is OR of falling edges.
`default_nettype none
module port_pin_control #(
  parameter bit FIRST_OPEN_DRAIN = 1'b0,
  parameter bit THIRD_INTERRUPTS = 1'b1,
  parameter bit CAPTURE_ON_PIN = 1'b1,
  parameter bit COMPARE_ON_PIN = 1'b1,
  parameter int RESET_DRIVE_CYCLES = port_pin_pkg::RESET_DRIVE_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] write_data,
  input wire logic first_direction_write,
  input wire logic first_value_write,
  input wire logic second_direction_write,
  input wire logic second_value_write,
  input wire logic third_direction_write,
  input wire logic third_value_write,
  input wire logic trigger_mode_write,
  input wire logic watchdog_expired,
  input wire logic timer_compare_one,
  input wire logic [7:0] first_pin_in,
  output logic [7:0] first_pin_out,
  output logic [7:0] first_pin_oe,
  input wire logic [7:0] second_pin_in,
  output logic [7:0] second_pin_out,
  output logic [7:0] second_pin_oe,
  input wire logic [5:0] third_pin_in,
  output logic [5:0] third_pin_out,
  output logic [5:0] third_pin_oe,
  output logic [5:0] third_pullup_en,
  input wire logic int_pin_in,
  input wire logic reset_n_pin_in,
  output logic reset_n_pin_out,
  output logic reset_n_pin_oe,
  output logic [7:0] first_port_direction,
  output logic [7:0] first_port_value,
  output logic [7:0] second_port_direction,
  output logic [7:0] second_port_value,
  output logic [5:0] third_port_direction,
  output logic [5:0] third_port_value,
  output logic [1:0] trigger_mode,
  output logic third_port_irq,
  output logic external_irq,
  output logic timer_capture_input,
  output logic controller_reset
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [port_pin_pkg::PIN_COUNT-1:0] pin_level;
  logic [port_pin_pkg::PIN_COUNT-1:0] pin_level_q;

  // Every pin passes the same filter, so all inputs see one common delay.
  pin_sync #(
    .WIDTH(port_pin_pkg::PIN_COUNT),
    .RESET_LEVEL('1)
  ) u_pin_sync (
    .mclk(mclk),
    .rst(rst),
    .pin({reset_n_pin_in, int_pin_in, third_pin_in, second_pin_in, first_pin_in}),
    .level(pin_level)
  );

  wire [7:0] first_level = pin_level[port_pin_pkg::FIRST_POS +: 8];
  wire [7:0] second_level = pin_level[port_pin_pkg::SECOND_POS +: 8];
  wire [5:0] third_level = pin_level[port_pin_pkg::THIRD_POS +: 6];
  wire [5:0] third_level_q = pin_level_q[port_pin_pkg::THIRD_POS +: 6];
  wire int_level = pin_level[port_pin_pkg::INT_POS];
  wire int_level_q = pin_level_q[port_pin_pkg::INT_POS];
  wire reset_level = pin_level[port_pin_pkg::RESET_POS];

  // ----------------------------------------------------------------
  // Reset handling
  // ----------------------------------------------------------------
  // The pin reset wins over everything and is not gated by any setting.
  wire soft_reset = rst | ~reset_level; // [RULE8]

  // The drive counter only listens to rst, so driving the pin low does not cut its own pulse short.
  // A new trip reloads the count, so trips in a row stretch the pulse.
  logic [port_pin_pkg::RESET_COUNT_WIDTH-1:0] drive_count;
  wire driving = drive_count != '0;
  wire [port_pin_pkg::RESET_COUNT_WIDTH-1:0] next_drive_count =
    watchdog_expired ? port_pin_pkg::RESET_COUNT_WIDTH'(RESET_DRIVE_CYCLES) :
    driving ? drive_count - 1'b1 : drive_count; // [RULE9]

  // ----------------------------------------------------------------
  // Helper: read value of a port, data for outputs and pin for inputs
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_mux(input logic [7:0] dir, input logic [7:0] data,
                                          input logic [7:0] pin);
    read_mux = (dir & data) | (~dir & pin); // [RULE12]
  endfunction : read_mux

  // ----------------------------------------------------------------
  // Helper: lines that changed towards the level asked for
  // ----------------------------------------------------------------
  function automatic logic [5:0] edge_lines(input logic [5:0] older, input logic [5:0] newer,
                                            input logic rising);
    edge_lines = rising ? (~older & newer) : (older & ~newer);
  endfunction : edge_lines

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // A low reset pin clears them just as rst does, and strobes seen meanwhile are lost.
  logic [7:0] first_dir;
  logic [7:0] first_data;
  logic [7:0] second_dir;
  logic [7:0] second_data;
  logic [5:0] third_dir;
  logic [5:0] third_data;
  logic [1:0] trigger;

  // ----------------------------------------------------------------
  // First port registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (soft_reset) begin
      first_dir <= port_pin_pkg::DIRECTION_RESET;
      first_data <= port_pin_pkg::VALUE_RESET;
    end else begin
      if (first_direction_write) first_dir <= write_data; // [RULE1]
      if (first_value_write) first_data <= write_data; // [RULE1]
    end
  end

  // ----------------------------------------------------------------
  // Second port registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (soft_reset) begin
      second_dir <= port_pin_pkg::DIRECTION_RESET;
      second_data <= port_pin_pkg::VALUE_RESET;
    end else begin
      if (second_direction_write) second_dir <= write_data; // [RULE3]
      if (second_value_write) second_data <= write_data; // [RULE3]
    end
  end

  // ----------------------------------------------------------------
  // Third port registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (soft_reset) begin
      third_dir <= port_pin_pkg::DIRECTION_RESET[5:0];
      third_data <= port_pin_pkg::VALUE_RESET[5:0];
    end else begin
      if (third_direction_write) third_dir <= write_data[5:0]; // [RULE11]
      if (third_value_write) third_data <= write_data[5:0]; // [RULE11]
    end
  end

  // ----------------------------------------------------------------
  // Trigger mode register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (soft_reset) begin
      trigger <= port_pin_pkg::TRIGGER_RESET;
    end else begin
      if (trigger_mode_write) trigger <= write_data[1:0]; // [RULE10]
    end
  end

  // ----------------------------------------------------------------
  // First and second port drivers
  // ----------------------------------------------------------------
  // Open drain only ever enables the driver to pull the line low.
  wire [7:0] next_first_out = FIRST_OPEN_DRAIN ? 8'h00 : first_data; // [RULE2]
  wire [7:0] next_first_oe = FIRST_OPEN_DRAIN ? (first_dir & ~first_data) : first_dir; // [RULE2]
  wire [7:0] next_second_out = second_data; // [RULE3]
  wire [7:0] next_second_oe = second_dir; // [RULE12]

  // ----------------------------------------------------------------
  // Third port drivers and pull-ups
  // ----------------------------------------------------------------
  // A line with a timer function is taken away from the general-purpose logic.
  wire [5:0] timer_lines = {4'h0, COMPARE_ON_PIN, CAPTURE_ON_PIN};
  wire [5:0] gp_dir = third_dir & ~timer_lines;
  wire [5:0] compare_mask = {4'h0, COMPARE_ON_PIN, 1'b0};

  wire [5:0] next_third_out = (third_data & ~compare_mask) |
    ({6{timer_compare_one}} & compare_mask); // [RULE7]
  wire [5:0] next_third_oe = gp_dir | compare_mask; // [RULE7]
  wire [5:0] next_third_pullup = THIRD_INTERRUPTS ? 6'h00 :
    (~gp_dir & ~timer_lines); // [RULE5] [RULE6] [RULE7]
  wire next_capture = CAPTURE_ON_PIN ? third_level[port_pin_pkg::CAPTURE_BIT] : 1'b1; // [RULE6]

  // ----------------------------------------------------------------
  // Interrupt detection
  // ----------------------------------------------------------------
  // Edges come from the filtered level and its copy one cycle older.
  wire [5:0] third_falls = edge_lines(third_level_q, third_level, 1'b0) & ~gp_dir & ~timer_lines; // [RULE4]
  wire next_third_irq = THIRD_INTERRUPTS && (|third_falls); // [RULE13]

  wire [5:0] int_rises = edge_lines({5'h00, int_level_q}, {5'h00, int_level}, 1'b1);
  wire [5:0] int_falls = edge_lines({5'h00, int_level_q}, {5'h00, int_level}, 1'b0);
  wire int_rise = int_rises[0];
  wire int_fall = int_falls[0];
  logic next_external_irq;

  always_comb begin
    case (trigger)
      port_pin_pkg::TRIGGER_LOW_LEVEL: next_external_irq = ~int_level; // [RULE10]
      port_pin_pkg::TRIGGER_RISING: next_external_irq = int_rise; // [RULE10]
      port_pin_pkg::TRIGGER_FALLING: next_external_irq = int_fall; // [RULE10]
      port_pin_pkg::TRIGGER_BOTH: next_external_irq = int_rise | int_fall; // [RULE10]
      default: next_external_irq = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Read-back values
  // ----------------------------------------------------------------
  wire [7:0] next_first_read = read_mux(first_dir, first_data, first_level); // [RULE1]
  wire [7:0] next_second_read = read_mux(second_dir, second_data, second_level); // [RULE3]
  wire [7:0] third_wide = read_mux({2'h0, gp_dir}, {2'h0, third_data}, {2'h0, third_level});
  wire [5:0] next_third_read = third_wide[5:0]; // [RULE11]

  // ----------------------------------------------------------------
  // Reset pin drive counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      drive_count <= '0;
    end else begin
      drive_count <= next_drive_count;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Request pulses are dropped while any reset is pending.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_level_q <= '1;
      first_pin_out <= 8'h00;
      first_pin_oe <= 8'h00;
      second_pin_out <= 8'h00;
      second_pin_oe <= 8'h00;
      third_pin_out <= 6'h00;
      third_pin_oe <= 6'h00;
      third_pullup_en <= 6'h00;
      reset_n_pin_out <= 1'b0;
      reset_n_pin_oe <= 1'b0;
      first_port_value <= 8'h00;
      second_port_value <= 8'h00;
      third_port_value <= 6'h00;
      third_port_irq <= 1'b0;
      external_irq <= 1'b0;
      timer_capture_input <= 1'b1;
      controller_reset <= 1'b1;
    end else begin
      pin_level_q <= pin_level;
      first_pin_out <= next_first_out;
      first_pin_oe <= next_first_oe;
      second_pin_out <= next_second_out;
      second_pin_oe <= next_second_oe;
      third_pin_out <= next_third_out;
      third_pin_oe <= next_third_oe;
      third_pullup_en <= next_third_pullup;
      reset_n_pin_out <= 1'b0;
      reset_n_pin_oe <= driving; // [RULE9]
      first_port_value <= next_first_read;
      second_port_value <= next_second_read;
      third_port_value <= next_third_read;
      third_port_irq <= next_third_irq & ~soft_reset;
      external_irq <= next_external_irq & ~soft_reset;
      timer_capture_input <= next_capture;
      controller_reset <= soft_reset; // [RULE8]
    end
  end

  // ----------------------------------------------------------------
  // Register mirrors
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      first_port_direction <= port_pin_pkg::DIRECTION_RESET;
      second_port_direction <= port_pin_pkg::DIRECTION_RESET;
      third_port_direction <= port_pin_pkg::DIRECTION_RESET[5:0];
      trigger_mode <= port_pin_pkg::TRIGGER_RESET;
    end else begin
      first_port_direction <= first_dir;
      second_port_direction <= second_dir;
      third_port_direction <= third_dir;
      trigger_mode <= trigger;
    end
  end

endmodule : port_pin_control
`default_nettype wire

// file: port_pin_props.sv
// Concurrent checks on the ports of the pin control block.
`default_nettype none
module port_pin_props #(
  parameter int RESET_DRIVE_CYCLES = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] write_data,
  input wire logic first_direction_write,
  input wire logic watchdog_expired,
  input wire logic [7:0] first_pin_out,
  input wire logic [7:0] first_pin_oe,
  input wire logic [7:0] first_port_direction,
  input wire logic [7:0] first_port_value,
  input wire logic [5:0] third_pin_in,
  input wire logic [5:0] third_pullup_en,
  input wire logic third_port_irq,
  input wire logic int_pin_in,
  input wire logic [1:0] trigger_mode,
  input wire logic external_irq,
  input wire logic reset_n_pin_in,
  input wire logic reset_n_pin_out,
  input wire logic reset_n_pin_oe,
  input wire logic controller_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (rst);

  wd_drive_a: assert property (watchdog_expired |-> ##2 reset_n_pin_oe)
    else $error("reset pin not driven after watchdog trip");
  drive_low_a: assert property (reset_n_pin_oe |-> !reset_n_pin_out)
    else $error("reset pin driven high");
  drive_len_a: assert property ($fell(reset_n_pin_oe) |-> $past(reset_n_pin_oe, RESET_DRIVE_CYCLES))
    else $error("reset pin drive too short");
  pin_reset_a: assert property (!reset_n_pin_in [*6] |-> controller_reset)
    else $error("low reset pin did not reset the controller");
  first_drive_a: assert property (first_pin_oe == first_port_direction
      && ((first_pin_out ^ first_port_value) & first_pin_oe) == 8'h00)
    else $error("first port drive differs from its registers");
  dir_write_a: assert property (first_direction_write && !controller_reset ##1 !controller_reset
      ##1 !controller_reset |-> first_port_direction == $past(write_data, 2))
    else $error("first port direction write lost");
  pullup_off_a: assert property (third_pullup_en == 6'h00)
    else $error("pull-up on in interrupt option");
  edge_irq_a: assert property (third_port_irq
      |-> ($past(third_pin_in, 6) & ~$past(third_pin_in, 5)) != 6'h00)
    else $error("third port request without a falling edge");
  level_irq_a: assert property ((trigger_mode == 2'h0 && !int_pin_in) [*7] |-> external_irq)
    else $error("low level on interrupt pin not reported");
endmodule : port_pin_props

bind port_pin_control port_pin_props #(.RESET_DRIVE_CYCLES(RESET_DRIVE_CYCLES)) u_props (.mclk, .rst,
  .write_data, .first_direction_write, .watchdog_expired, .first_pin_out, .first_pin_oe, .first_port_direction,
  .first_port_value, .third_pin_in, .third_pullup_en, .third_port_irq, .int_pin_in, .trigger_mode,
  .external_irq, .reset_n_pin_in, .reset_n_pin_out, .reset_n_pin_oe, .controller_reset);
`default_nettype wire

// file: board_line.sv
// Board side of a group of pins: external drivers and pull-up resistors.
`default_nettype none
module board_line #(
  parameter int W = 8
) (
  input wire logic [W-1:0] dut_out,
  input wire logic [W-1:0] dut_oe,
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_en,
  output logic [W-1:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Undriven lines float high on the board pull-ups; a low from either side wins.
  assign level = (~dut_oe | dut_out) & (~ext_en | ext_val);
endmodule : board_line
`default_nettype wire

// file: port_pin_control_bench.sv
// Self-checking bench for the pin control block on its board model.
`default_nettype none
module port_pin_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, watchdog_expired, timer_compare_one, int_pin_in, reset_n_pin_in;
  logic [7:0] write_data, first_pin_in, first_pin_out, first_pin_oe, second_pin_in, second_pin_out, second_pin_oe;
  logic [7:0] first_port_direction, first_port_value, second_port_direction, second_port_value, e1v, e1e, e2v, e2e;
  logic [5:0] third_pin_in, third_pin_out, third_pin_oe, third_pullup_en, third_port_direction, third_port_value;
  logic [5:0] e3v, e3e;
  logic [6:0] wr;
  logic [1:0] trigger_mode;
  logic reset_n_pin_out, reset_n_pin_oe, third_port_irq, external_irq, timer_capture_input, controller_reset;
  logic erv, ere;
  int mismatches, n_checks;

  port_pin_control #(.RESET_DRIVE_CYCLES(4)) DUT (.mclk, .rst, .write_data, .first_direction_write(wr[0]),
    .first_value_write(wr[1]), .second_direction_write(wr[2]), .second_value_write(wr[3]),
    .third_direction_write(wr[4]), .third_value_write(wr[5]), .trigger_mode_write(wr[6]), .watchdog_expired,
    .timer_compare_one, .first_pin_in, .first_pin_out, .first_pin_oe, .second_pin_in, .second_pin_out,
    .second_pin_oe, .third_pin_in, .third_pin_out, .third_pin_oe, .third_pullup_en, .int_pin_in,
    .reset_n_pin_in, .reset_n_pin_out, .reset_n_pin_oe, .first_port_direction, .first_port_value,
    .second_port_direction, .second_port_value, .third_port_direction, .third_port_value, .trigger_mode,
    .third_port_irq, .external_irq, .timer_capture_input, .controller_reset);
  board_line #(.W(8)) pins_a (.dut_out(first_pin_out), .dut_oe(first_pin_oe), .ext_val(e1v), .ext_en(e1e),
    .level(first_pin_in));
  board_line #(.W(8)) pins_b (.dut_out(second_pin_out), .dut_oe(second_pin_oe), .ext_val(e2v), .ext_en(e2e),
    .level(second_pin_in));
  board_line #(.W(6)) pins_c (.dut_out(third_pin_out), .dut_oe(third_pin_oe), .ext_val(e3v), .ext_en(e3e),
    .level(third_pin_in));
  board_line #(.W(1)) pins_r (.dut_out(reset_n_pin_out), .dut_oe(reset_n_pin_oe), .ext_val(erv),
    .ext_en(ere), .level(reset_n_pin_in));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick

  task automatic write(input int sel, input logic [7:0] d);
    wr[sel] = 1'b1;
    write_data = d;
    tick(1);
    wr = '0;
    tick(1);
  endtask : write

  task automatic t_ports();
    e1e = 8'h0f;
    e1v = 8'h06;
    e2e = 8'hc3;
    e2v = 8'h5a;
    write(0, 8'hf0);
    write(1, 8'ha5);
    write(2, 8'h3c);
    write(3, 8'h81);
    tick(8);
    cmp(first_pin_oe, 8'hf0);
    cmp(first_pin_out & first_pin_oe, 8'ha0);
    cmp(first_port_value, 8'ha6);
    cmp(first_port_direction, 8'hf0);
    cmp(second_pin_oe, 8'h3c);
    cmp(second_pin_out, 8'h81);
    cmp(second_port_direction, 8'h3c);
    cmp(second_port_value, 8'h42);
    e1v = 8'h09;
    e2v = 8'ha5;
    tick(8);
    cmp(first_port_value, 8'ha9);
    cmp(second_port_value, 8'h81);
  endtask : t_ports

  task automatic t_reset_pin();
    ere = 1'b1;
    tick(8);
    write(2, 8'h77);
    cmp(8'(controller_reset), 8'h01);
    ere = 1'b0;
    tick(8);
    cmp(8'(controller_reset), 8'h00);
    cmp(first_port_direction, 8'h00);
    cmp(second_port_direction, 8'h00);
  endtask : t_reset_pin

  task automatic t_third();
    timer_compare_one = 1'b1;
    e3e = 6'h31;
    e3v = 6'h10;
    write(4, 8'h0c);
    write(5, 8'h3f);
    tick(8);
    cmp(8'(third_pin_oe), 8'h0e);
    cmp(8'(third_pin_out & third_pin_oe), 8'h0e);
    cmp(8'(third_pullup_en), 8'h00);
    cmp(8'(third_port_direction), 8'h0c);
    cmp(8'(third_port_value), 8'h1e);
    cmp(8'(timer_capture_input), 8'h00);
    timer_compare_one = 1'b0;
    tick(4);
    cmp(8'(third_pin_out[1]), 8'h00);
  endtask : t_third

  task automatic t_third_irq();
    logic [5:0] masks[2] = '{6'h30, 6'h01};
    int c;
    for (int k = 0; k < 2; k++) begin
      e3v = 6'h31;
      tick(10);
      e3v = 6'h31 & ~masks[k];
      c = 0;
      repeat (12) begin
        tick(1);
        c += int'(third_port_irq);
      end
      cmp(8'(c), k == 0 ? 8'h01 : 8'h00);
    end
    cmp(8'(timer_capture_input), 8'h00);
  endtask : t_third_irq

  task automatic t_ext_irq();
    logic [7:0] expect_n[4] = '{8'h08, 8'h01, 8'h01, 8'h02};
    int c;
    for (int m = 0; m < 4; m++) begin
      write(6, 8'(m));
      tick(8);
      cmp(8'(trigger_mode), 8'(m));
      c = 0;
      for (int i = 0; i < 24; i++) begin
        int_pin_in = (i < 8) ? 1'b0 : 1'b1;
        tick(1);
        c += int'(external_irq);
      end
      cmp(8'(c), expect_n[m]);
    end
  endtask : t_ext_irq

  task automatic t_watchdog();
    int c;
    int seen;
    e1e = 8'h00;
    write(0, 8'hff);
    watchdog_expired = 1'b1;
    tick(1);
    watchdog_expired = 1'b0;
    c = 0;
    seen = 0;
    repeat (30) begin
      tick(1);
      c += int'(reset_n_pin_oe);
      seen |= int'(controller_reset);
    end
    cmp(8'(c), 8'h04);
    cmp(8'(reset_n_pin_out), 8'h00);
    cmp(8'(seen), 8'h01);
    cmp(first_port_direction, 8'h00);
  endtask : t_watchdog

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  initial begin
    {rst, watchdog_expired, timer_compare_one, int_pin_in} = 4'h9;
    {wr, write_data, e1v, e1e, e2v, e2e, e3v, e3e, erv, ere} = '0;
    mismatches = 0;
    n_checks = 0;
    tick(16);
    rst = 1'b0;
    tick(3);
    cmp(first_port_direction, 8'h00);
    t_ports();
    t_reset_pin();
    t_third();
    t_third_irq();
    t_ext_irq();
    t_watchdog();
    end_of_test();
  end
endmodule : port_pin_control_bench
`default_nettype wire
